/* File: src/spd_pkg.sv */
// Constants, types and shared functions of the serial port with DMA.
// Assumes a single 200 MHz clock domain and a plain register port.
package spd_pkg;
  localparam int AW = 12;
  localparam int CW = 16;
  localparam int NEV = 11;
  localparam int PIN_W = 5;
  localparam int FD = 8;
  localparam int FAW = 3;
  localparam int FPW = 4;
  localparam logic [FPW-1:0] FIFO_FULL = 4'h8;
  localparam logic [FPW-1:0] RTS_MARGIN = 4'h4;

  // Register offsets.
  localparam logic [AW-1:0] OFF_STARTRX = 12'h000;
  localparam logic [AW-1:0] OFF_RX_STOP = 12'h004;
  localparam logic [AW-1:0] OFF_STARTTX = 12'h008;
  localparam logic [AW-1:0] OFF_TX_STOP = 12'h00c;
  localparam logic [AW-1:0] OFF_RX_FLUSH = 12'h02c;
  localparam logic [AW-1:0] OFF_SHORTCUT = 12'h200;
  localparam logic [AW-1:0] OFF_INTERRUPT_ENABLE = 12'h300;
  localparam logic [AW-1:0] OFF_INTERRUPT_ENABLE_SET = 12'h304;
  localparam logic [AW-1:0] OFF_INTERRUPT_ENABLE_CLEAR = 12'h308;
  localparam logic [AW-1:0] OFF_ERR = 12'h480;
  localparam logic [AW-1:0] OFF_ENABLE = 12'h500;
  localparam logic [AW-1:0] OFF_BITRATE = 12'h524;
  localparam logic [AW-1:0] OFF_RXPTR = 12'h534;
  localparam logic [AW-1:0] OFF_RXSIZE = 12'h538;
  localparam logic [AW-1:0] OFF_RXAMT = 12'h53c;
  localparam logic [AW-1:0] OFF_TXPTR = 12'h544;
  localparam logic [AW-1:0] OFF_TXSIZE = 12'h548;
  localparam logic [AW-1:0] OFF_TXAMT = 12'h54c;
  localparam logic [AW-1:0] OFF_CONFIG = 12'h56c;

  // Pin selects, in the order rts, txd, cts, rxd.
  localparam int PS_RTS = 0;
  localparam int PS_TXD = 1;
  localparam int PS_CTS = 2;
  localparam int PS_RXD = 3;
  localparam logic [AW-1:0] PS_OFF [4] = '{12'h508, 12'h50c, 12'h510, 12'h514};
  localparam int PSEL_OFF = 31;
  localparam logic [31:0] PSEL_RST = 32'hffffffff;

  // Event indices and their offsets.
  localparam int EV_CTS = 0;
  localparam int EV_CTS_HIGH = 1;
  localparam int EV_RXDRDY = 2;
  localparam int EV_ENDRX = 3;
  localparam int EV_TXDRDY = 4;
  localparam int EV_ENDTX = 5;
  localparam int EV_ERROR = 6;
  localparam int EV_RX_TIMEOUT = 7;
  localparam int EV_RXSTART = 8;
  localparam int EV_TXSTART = 9;
  localparam int EV_TXSTOP = 10;
  localparam logic [AW-1:0] EV_OFF [NEV] = '{12'h100, 12'h104, 12'h108, 12'h110,
    12'h11c, 12'h120, 12'h124, 12'h144, 12'h14c, 12'h150, 12'h158};

  // Field positions and reset values.
  localparam int SH_ENDRX_STARTRX = 0;
  localparam int SH_ENDRX_RX_STOP = 1;
  localparam int ERR_OVR = 0;
  localparam int ERR_PAR = 1;
  localparam int ERR_FRM = 2;
  localparam int CFG_HWFC = 0;
  localparam int CFG_PAR = 1;
  localparam int CFG_STOP2 = 4;
  localparam logic [3:0] EN_ON = 4'h1;
  localparam logic [31:0] BITRATE_RST = 32'h000006c8;
  localparam logic [3:0] FR_BASE = 4'ha;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_REQ = 4'b0010,
    TX_LOAD = 4'b0100,
    TX_SEND = 4'b1000
  } spd_tx_t;

  typedef enum logic [1:0] {
    RL_IDLE = 2'b01,
    RL_BITS = 2'b10
  } spd_rl_t;

  // One-hot decode of an event offset.
  function automatic logic [NEV-1:0] ev_dec(input logic [AW-1:0] a);
    logic [NEV-1:0] h;
    h = '0;
    for (int i = 0; i < NEV; i++) begin
      h[i] = (a == EV_OFF[i]);
    end
    return h;
  endfunction

  // Bits in a frame: start, eight data, parity, stops.
  function automatic logic [3:0] frame_len(input logic par, input logic stop2);
    return FR_BASE + {3'h0, par} + {3'h0, stop2};
  endfunction
endpackage

/* File: src/spd_mem_if.sv */
// Port bundle between the controller and its receive queue memory.
// Assumes both ends run on clk_sys.
`timescale 1ns/100ps
interface spd_mem_if;
  logic wr_en;
  logic [spd_pkg::FAW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [spd_pkg::FAW-1:0] rd_addr;
  logic [7:0] rd_data;
  modport owner (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

/* File: src/spd_fifo_mem.sv */
// Byte store of the internal receive queue, read data registered.
// Assumes the owner keeps the queue pointers.
`timescale 1ns/100ps
module spd_fifo_mem (
  input logic clk_sys,
  input logic ce,
  spd_mem_if.mem port
);
  import spd_pkg::*;
  logic [7:0] ram_q [FD];
  logic [7:0] rd_q;

  // Storage needs no reset; the pointers decide what is valid.
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (port.wr_en) begin
        ram_q[port.wr_addr] <= port.wr_data;
      end
      rd_q <= ram_q[port.rd_addr];
    end
  end
  assign port.rd_data = rd_q;
endmodule // spd_fifo_mem

/* File: src/spd_uart.sv */
// Serial port with DMA: registers, pin routing, transmitter and receiver.
// Assumes a byte-wide memory port that answers reads one cycle later.
`timescale 1ns/100ps
module spd_uart (
  input logic clk_sys,
  input logic sys_rst,
  input logic ce,
  input logic system_off,
  input logic [spd_pkg::AW-1:0] bus_addr,
  input logic [31:0] bus_wdata,
  input logic bus_wr,
  input logic bus_rd,
  output logic [31:0] bus_rdata,
  input logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  output logic dma_rd_en,
  output logic [31:0] dma_rd_addr,
  input logic [7:0] dma_rd_data,
  output logic dma_wr_en,
  output logic [31:0] dma_wr_addr,
  output logic [7:0] dma_wr_data
);
  import spd_pkg::*;

  logic [NEV-1:0] ev_q, ev_set;
  logic [2:0] err_q, err_set;
  logic [31:0] shortcut_q, interrupt_enable_q, enable_q, bit_rate_q, cfg_q, rdata_q;
  logic [31:0] psel_q [4];
  logic [31:0] rx_ptr_q, tx_ptr_q, rx_base_q, tx_base_q, rd_addr_q, wr_addr_q;
  logic [CW-1:0] rx_max_q, tx_max_q, rx_lim_q, tx_lim_q, rx_amt_q, tx_amt_q;
  logic [31:0] pout_q, poe_q, pout_d, poe_d, rd_val;
  spd_tx_t tx_st_q;
  spd_rl_t rl_st_q;
  logic tx_act_q, tx_stop_q, cts_prev_q;
  logic [11:0] tx_fr_q, rx_sh_q;
  logic [3:0] tx_bits_q, rx_cnt_q;
  logic [15:0] tx_bc_q, rx_bc_q;
  logic rx_on_q, rx_stop_q, flush_q, rx_endsent_q, rx_fin_q, drn_q;
  logic [FPW-1:0] wp_q, rp_q;
  logic wr_en_q;
  logic [7:0] wr_data_q;
  spd_mem_if mem_bus ();

  spd_fifo_mem u_mem (
    .clk_sys(clk_sys),
    .ce(ce),
    .port(mem_bus.mem)
  );

  // Bus decode; tasks only act while the port is enabled.
  wire port_on = (enable_q[3:0] == EN_ON);
  wire wr_task = bus_wr && bus_wdata[0] && port_on;
  wire [NEV-1:0] ev_hit = ev_dec(bus_addr);
  wire sc_endrx = port_on && ev_set[EV_ENDRX];
  wire go_startrx = (wr_task && bus_addr == OFF_STARTRX) || (sc_endrx && shortcut_q[SH_ENDRX_STARTRX]);
  wire go_rx_stop = (wr_task && bus_addr == OFF_RX_STOP) || (sc_endrx && shortcut_q[SH_ENDRX_RX_STOP]);
  wire go_starttx = wr_task && bus_addr == OFF_STARTTX;
  wire go_tx_stop = wr_task && bus_addr == OFF_TX_STOP;
  wire go_flush = wr_task && bus_addr == OFF_RX_FLUSH;
  wire par_on = cfg_q[CFG_PAR];
  wire hwfc = cfg_q[CFG_HWFC];
  wire [15:0] bit_per = (bit_rate_q[15:0] == 16'h0) ? 16'h1 : bit_rate_q[15:0];

  // Selected pin level; a disconnected select reads as idle high.
  function automatic logic pin_sel(input logic [31:0] pins, input logic [31:0] ps);
    return ps[PSEL_OFF] ? 1'b1 : pins[ps[PIN_W-1:0]];
  endfunction

  // Input routing, only live while enabled.
  wire cts_con = port_on && !psel_q[PS_CTS][PSEL_OFF];
  wire cts_now = port_on ? pin_sel(pin_in, psel_q[PS_CTS]) : 1'b1;
  wire rx_pin = port_on ? pin_sel(pin_in, psel_q[PS_RXD]) : 1'b1;
  wire cts_ok = !hwfc || !cts_now;

  // Queue state and the request-to-send level.
  wire [FPW-1:0] fcount = wp_q - rp_q;
  wire fempty = (fcount == '0);
  wire ffull = (fcount == FIFO_FULL);
  wire rts_act = rx_on_q && !rx_stop_q && (fcount < FIFO_FULL - RTS_MARGIN);
  wire rts_line = hwfc ? !rts_act : 1'b1;
  wire tx_line = (tx_st_q == TX_SEND) ? tx_fr_q[0] : 1'b1;

  // Transmit sequencing terms.
  wire tx_tick = (tx_st_q == TX_SEND) && (tx_bc_q == 16'h0);
  wire tx_byte_done = tx_tick && (tx_bits_q == 4'h1);
  wire tx_fin = (tx_st_q == TX_IDLE) && tx_act_q && (tx_amt_q == tx_lim_q || tx_stop_q);
  wire tx_go = (tx_st_q == TX_IDLE) && tx_act_q && !tx_stop_q && tx_amt_q != tx_lim_q && cts_ok;
  wire [7:0] tx_byte = dma_rd_data;
  wire tx_par = par_on ? ^tx_byte : 1'b1;

  // Receive decode of a finished frame.
  wire [3:0] rx_len = frame_len(par_on, 1'b0);
  wire [7:0] rx_byte = rx_sh_q[8:1];
  wire rx_start_ok = rx_fin_q && !rx_sh_q[0];
  wire rx_stop_ok = rx_sh_q[rx_len - 4'h1];
  wire rx_good = rx_start_ok && rx_stop_ok;
  wire rx_push = rx_good && !ffull;
  wire rx_full = (rx_amt_q == rx_lim_q);
  wire can_drain = (rx_on_q || flush_q) && !fempty && !rx_full && !drn_q;
  wire rx_quiet = rx_stop_q && (rl_st_q == RL_IDLE) && !drn_q && !rx_fin_q && (fempty || rx_full);
  wire flush_done = flush_q && !drn_q && (fempty || rx_full);
  wire rx_endrx = !rx_endsent_q && ((rx_on_q && (rx_full || rx_quiet)) || flush_done);

  // Error causes; a framing error drops the byte, parity keeps it.
  assign err_set[ERR_OVR] = rx_good && ffull;
  assign err_set[ERR_PAR] = rx_good && par_on && (rx_sh_q[9] != ^rx_byte);
  assign err_set[ERR_FRM] = rx_start_ok && !rx_stop_ok;

  // Event sources.
  assign ev_set[EV_CTS] = cts_con && !cts_now && cts_prev_q;
  assign ev_set[EV_CTS_HIGH] = cts_con && cts_now && !cts_prev_q;
  assign ev_set[EV_RXDRDY] = rx_good;
  assign ev_set[EV_ENDRX] = rx_endrx;
  assign ev_set[EV_TXDRDY] = tx_byte_done;
  assign ev_set[EV_ENDTX] = tx_fin;
  assign ev_set[EV_ERROR] = |err_set;
  assign ev_set[EV_RX_TIMEOUT] = rx_quiet && rx_endsent_q;
  assign ev_set[EV_RXSTART] = go_startrx && !rx_stop_q;
  assign ev_set[EV_TXSTART] = go_starttx && !tx_act_q;
  assign ev_set[EV_TXSTOP] = (tx_st_q == TX_IDLE) && tx_stop_q;

  // Queue memory connections.
  assign mem_bus.wr_en = rx_push;
  assign mem_bus.wr_addr = wp_q[FAW-1:0];
  assign mem_bus.wr_data = rx_byte;
  assign mem_bus.rd_addr = rp_q[FAW-1:0];

  // Read selection; tasks and unmapped offsets read zero.
  always_comb begin
    rd_val = '0;
    for (int i = 0; i < NEV; i++) begin
      if (ev_hit[i]) begin
        rd_val = {31'h0, ev_q[i]};
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (bus_addr == PS_OFF[i]) begin
        rd_val = psel_q[i];
      end
    end
    case (bus_addr)
      OFF_SHORTCUT: rd_val = shortcut_q;
      OFF_INTERRUPT_ENABLE, OFF_INTERRUPT_ENABLE_SET, OFF_INTERRUPT_ENABLE_CLEAR: rd_val = interrupt_enable_q;
      OFF_ERR: rd_val = {29'h0, err_q};
      OFF_ENABLE: rd_val = enable_q;
      OFF_BITRATE: rd_val = bit_rate_q;
      OFF_RXPTR: rd_val = rx_ptr_q;
      OFF_RXSIZE: rd_val = {16'h0, rx_max_q};
      OFF_RXAMT: rd_val = {16'h0, rx_amt_q};
      OFF_TXPTR: rd_val = tx_ptr_q;
      OFF_TXSIZE: rd_val = {16'h0, tx_max_q};
      OFF_TXAMT: rd_val = {16'h0, tx_amt_q};
      OFF_CONFIG: rd_val = cfg_q;
      default: ;
    endcase
  end

  // Output pin routing; nothing is driven while the port is disabled.
  always_comb begin
    pout_d = '1;
    poe_d = '0;
    if (port_on && !psel_q[PS_TXD][PSEL_OFF]) begin
      poe_d[psel_q[PS_TXD][PIN_W-1:0]] = 1'b1;
      pout_d[psel_q[PS_TXD][PIN_W-1:0]] = tx_line;
    end
    if (port_on && !psel_q[PS_RTS][PSEL_OFF]) begin
      poe_d[psel_q[PS_RTS][PIN_W-1:0]] = 1'b1;
      pout_d[psel_q[PS_RTS][PIN_W-1:0]] = rts_line;
    end
  end

  // Register file. Hardware sets win over software clears.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ev_q <= '0;
      err_q <= '0;
      shortcut_q <= '0;
      interrupt_enable_q <= '0;
      enable_q <= '0;
      bit_rate_q <= BITRATE_RST;
      cfg_q <= '0;
      rx_ptr_q <= '0;
      tx_ptr_q <= '0;
      rx_max_q <= '0;
      tx_max_q <= '0;
      rdata_q <= '0;
      psel_q <= '{default: PSEL_RST};
    end else if (ce) begin
      ev_q <= (ev_q & ~((bus_wr && !bus_wdata[0]) ? ev_hit : '0)) | ev_set;
      err_q <= (err_q & ~((bus_wr && bus_addr == OFF_ERR) ? bus_wdata[2:0] : 3'h0)) | err_set;
      rdata_q <= bus_rd ? rd_val : '0;
      if (bus_wr) begin
        case (bus_addr)
          OFF_SHORTCUT: shortcut_q <= bus_wdata;
          OFF_INTERRUPT_ENABLE: interrupt_enable_q <= bus_wdata;
          OFF_INTERRUPT_ENABLE_SET: interrupt_enable_q <= interrupt_enable_q | bus_wdata;
          OFF_INTERRUPT_ENABLE_CLEAR: interrupt_enable_q <= interrupt_enable_q & ~bus_wdata;
          OFF_ENABLE: enable_q <= bus_wdata;
          OFF_BITRATE: bit_rate_q <= bus_wdata;
          OFF_RXPTR: rx_ptr_q <= bus_wdata;
          OFF_RXSIZE: rx_max_q <= bus_wdata[CW-1:0];
          OFF_TXPTR: tx_ptr_q <= bus_wdata;
          OFF_TXSIZE: tx_max_q <= bus_wdata[CW-1:0];
          OFF_CONFIG: cfg_q <= bus_wdata;
          default: ;
        endcase
      end
      // Selects are ignored while enabled and wiped when the system goes off.
      for (int i = 0; i < 4; i++) begin
        if (system_off) begin
          psel_q[i] <= PSEL_RST;
        end else if (bus_wr && !port_on && bus_addr == PS_OFF[i]) begin
          psel_q[i] <= bus_wdata;
        end
      end
    end
  end

  // Registered pins and line-side sampling.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pout_q <= '1;
      poe_q <= '0;
      cts_prev_q <= 1'b1;
    end else if (ce) begin
      pout_q <= pout_d;
      poe_q <= poe_d;
      cts_prev_q <= cts_now;
    end
  end

  // Transmitter: fetch a byte, build the frame, shift it out LSB first.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_st_q <= TX_IDLE;
      tx_act_q <= 1'b0;
      tx_stop_q <= 1'b0;
      tx_base_q <= '0;
      tx_lim_q <= '0;
      tx_amt_q <= '0;
      tx_fr_q <= '1;
      tx_bits_q <= '0;
      tx_bc_q <= '0;
      rd_addr_q <= '0;
    end else if (ce) begin
      if (go_starttx && !tx_act_q) begin
        tx_act_q <= 1'b1;
        tx_base_q <= tx_ptr_q;
        tx_lim_q <= tx_max_q;
        tx_amt_q <= '0;
      end else if (tx_fin) begin
        tx_act_q <= 1'b0;
      end
      if (go_tx_stop) begin
        tx_stop_q <= 1'b1;
      end else if (tx_st_q == TX_IDLE) begin
        tx_stop_q <= 1'b0;
      end
      unique case (tx_st_q)
        TX_IDLE: begin
          if (tx_go) begin
            tx_st_q <= TX_REQ;
            rd_addr_q <= tx_base_q + {16'h0, tx_amt_q};
          end
        end
        TX_REQ: tx_st_q <= TX_LOAD;
        TX_LOAD: begin
          tx_st_q <= TX_SEND;
          tx_fr_q <= {2'b11, tx_par, tx_byte, 1'b0};
          tx_bits_q <= frame_len(par_on, cfg_q[CFG_STOP2]);
          tx_bc_q <= bit_per - 16'h1;
        end
        TX_SEND: begin
          if (tx_tick) begin
            tx_fr_q <= {1'b1, tx_fr_q[11:1]};
            tx_bits_q <= tx_bits_q - 4'h1;
            tx_bc_q <= bit_per - 16'h1;
            if (tx_byte_done) begin
              tx_st_q <= TX_IDLE;
              tx_amt_q <= tx_amt_q + 16'h1;
            end
          end else begin
            tx_bc_q <= tx_bc_q - 16'h1;
          end
        end
      endcase
    end
  end

  // Receive line: sample each bit in its middle.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rl_st_q <= RL_IDLE;
      rx_sh_q <= '0;
      rx_cnt_q <= '0;
      rx_bc_q <= '0;
      rx_fin_q <= 1'b0;
    end else if (ce) begin
      rx_fin_q <= 1'b0;
      unique case (rl_st_q)
        RL_IDLE: begin
          if (rx_on_q && !rx_pin) begin
            rl_st_q <= RL_BITS;
            rx_bc_q <= {1'b0, bit_per[15:1]};
            rx_cnt_q <= '0;
          end
        end
        RL_BITS: begin
          if (rx_bc_q == 16'h0) begin
            rx_sh_q[rx_cnt_q] <= rx_pin;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            rx_bc_q <= bit_per - 16'h1;
            if (rx_cnt_q == rx_len - 4'h1) begin
              rl_st_q <= RL_IDLE;
              rx_fin_q <= 1'b1;
            end
          end else begin
            rx_bc_q <= rx_bc_q - 16'h1;
          end
        end
      endcase
    end
  end

  // Receive queue and buffer drain, stop and flush sequencing.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_on_q <= 1'b0;
      rx_stop_q <= 1'b0;
      flush_q <= 1'b0;
      rx_endsent_q <= 1'b0;
      rx_base_q <= '0;
      rx_lim_q <= '0;
      rx_amt_q <= '0;
      wp_q <= '0;
      rp_q <= '0;
      drn_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else if (ce) begin
      wr_en_q <= 1'b0;
      if (rx_push) begin
        wp_q <= wp_q + 4'h1;
      end
      if (can_drain) begin
        rp_q <= rp_q + 4'h1;
      end
      drn_q <= can_drain;
      if (drn_q) begin
        wr_en_q <= 1'b1;
        wr_addr_q <= rx_base_q + {16'h0, rx_amt_q};
        wr_data_q <= mem_bus.rd_data;
        rx_amt_q <= rx_amt_q + 16'h1;
      end
      if (rx_endrx) begin
        rx_endsent_q <= 1'b1;
        flush_q <= 1'b0;
      end
      if (ev_set[EV_RX_TIMEOUT]) begin
        rx_on_q <= 1'b0;
        rx_stop_q <= 1'b0;
      end else if (go_rx_stop && rx_on_q) begin
        rx_stop_q <= 1'b1;
      end
      // A start restarts the buffer; it is held off while a stop is pending.
      if (go_startrx && !rx_stop_q) begin
        rx_on_q <= 1'b1;
        rx_endsent_q <= 1'b0;
        rx_base_q <= rx_ptr_q;
        rx_lim_q <= rx_max_q;
        rx_amt_q <= '0;
      end else if (go_flush && !rx_on_q && !flush_q) begin
        flush_q <= 1'b1;
        rx_endsent_q <= 1'b0;
        rx_base_q <= rx_ptr_q;
        rx_lim_q <= rx_max_q;
        rx_amt_q <= '0;
      end
    end
  end

  assign bus_rdata = rdata_q;
  assign pin_out = pout_q;
  assign pin_oe = poe_q;
  assign dma_rd_en = (tx_st_q == TX_REQ);
  assign dma_rd_addr = rd_addr_q;
  assign dma_wr_en = wr_en_q;
  assign dma_wr_addr = wr_addr_q;
  assign dma_wr_data = wr_data_q;

  // Checks of the documented behaviour.
  AST_TX_PARITY: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ce && tx_st_q == TX_LOAD && par_on |=> tx_fr_q[9] == ^tx_fr_q[8:1])
    else $error("Transmit parity bit is not even.");
  AST_TX_STOP_LEN: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ce && tx_st_q == TX_LOAD |=> tx_bits_q == frame_len($past(par_on), $past(cfg_q[CFG_STOP2])))
    else $error("Frame length ignores stop bit setting.");
  AST_PINS_OFF: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ce && !port_on |=> pin_oe == '0)
    else $error("Pin driven while port disabled.");
  AST_ERR_W1C: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ce && bus_wr && bus_addr == OFF_ERR && bus_wdata[ERR_FRM] && !err_set[ERR_FRM] |=> !err_q[ERR_FRM])
    else $error("Error cause bit not cleared by write of one.");
  AST_SHORT_START: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ce && port_on && shortcut_q[SH_ENDRX_STARTRX] && ev_set[EV_ENDRX] && !rx_stop_q |=> rx_on_q && rx_amt_q == '0)
    else $error("Shortcut did not fire the start task.");
  AST_RX_LIMIT: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rx_amt_q <= rx_lim_q)
    else $error("Receive count passed the buffer size.");
  AST_TX_LIMIT: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    tx_act_q |-> tx_amt_q <= tx_lim_q)
    else $error("Transmit count passed the buffer size.");
  AST_CTS_HIGH_EVENT: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ce && cts_con && cts_now && !cts_prev_q |=> ev_q[EV_CTS_HIGH])
    else $error("Clear-to-send release did not set its event.");
  AST_TASK_READS_ZERO: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ce && bus_rd && bus_addr == OFF_TX_STOP |=> bus_rdata == '0)
    else $error("Task register read nonzero.");
  AST_EVENT_STICKY: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    ce && ev_q[EV_RXDRDY] && !(bus_wr && ev_hit[EV_RXDRDY] && !bus_wdata[0]) |=> ev_q[EV_RXDRDY])
    else $error("Event dropped without a software clear.");
endmodule // spd_uart

/* File: tb/spd_remote_model.sv */
// Remote serial device as seen from the port's line side.
// Assumes the bench places its lines on input pins of the port.
`timescale 1ns/100ps
module spd_remote_model (
  input wire logic clk_sys,
  input wire logic hold_off,
  input wire logic send,
  input wire logic [7:0] data,
  output logic rx_line,
  output logic cts_n
);
  logic [10:0] sh_q = '1;
  logic [3:0] left_q = '0;
  logic [1:0] div_q = '0;
  // Clear to send is active low, so holding off the port drives the line high.
  always_ff @(posedge clk_sys) begin
    cts_n <= hold_off;
  end
  // One frame per send: start, data LSB first, even parity, one stop; four clocks a bit.
  always_ff @(posedge clk_sys) begin
    if (send && left_q == 4'h0) begin
      sh_q <= {1'b1, ^data, data, 1'b0};
      left_q <= 4'hb;
      div_q <= 2'h0;
    end else if (left_q != 4'h0) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        sh_q <= {1'b1, sh_q[10:1]};
        left_q <= left_q - 4'h1;
      end
    end
  end
  // Between frames the line rests at its idle level, as an input must see while no frame runs.
  assign rx_line = sh_q[0];
endmodule // spd_remote_model

/* File: tb/test_uart_dma_control_map.sv */
// Bench for the serial port with DMA: register map, pin routing and line events.
// Assumes the remote model sits on pin 2 (receive) and pin 3 (clear to send).
`timescale 1ns/100ps
module test_uart_dma_control_map;
  import spd_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic system_off = 1'b0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic stall = 1'b0;
  logic [AW-1:0] bus_addr = '0;
  logic [31:0] bus_wdata = '0;
  logic [31:0] bus_rdata, pin_in, pin_out, pin_oe;
  logic rx_line, cts_n;
  logic rx_go = 1'b0;
  logic dma_rd_en, dma_wr_en;
  logic [7:0] dma_wr_data;
  logic [7:0] seen_data = '0;
  logic [31:0] dma_rd_addr, dma_wr_addr;
  logic [31:0] seen_addr = '0;
  int n_reads = 0;
  int n_fail = 0;
  int comparisons = 0;
  // Clock of 200 MHz.
  always #2.5 clk_sys = ~clk_sys;
  // Pins not owned by the remote device rest high, like pulled-up inputs.
  assign pin_in = {28'hfffffff, cts_n, rx_line, 2'h3};
  spd_remote_model remote (.clk_sys(clk_sys), .hold_off(stall), .send(rx_go), .data(8'h4a), .rx_line(rx_line),
    .cts_n(cts_n));
  spd_uart dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1), .system_off(system_off),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .dma_rd_en(dma_rd_en),
    .dma_rd_addr(dma_rd_addr), .dma_rd_data(8'hff),
    .dma_wr_en(dma_wr_en), .dma_wr_addr(dma_wr_addr), .dma_wr_data(dma_wr_data));
  // Count buffer reads and keep the last buffer write, so the tasks can judge them later.
  always @(posedge clk_sys) begin
    if (dma_rd_en) n_reads <= n_reads + 1;
    if (dma_wr_en) begin
      seen_addr <= dma_wr_addr;
      seen_data <= dma_wr_data;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are looked at there.
  task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, e);
  endtask
  task automatic t_reset;
    rd(12'h524, 32'h000006c8);
    rd(12'h508, 32'hffffffff);
    rd(12'h56c, 32'h00000000);
    rd(12'h480, 32'h00000000);
    rd(12'h7fc, 32'h00000000);
    chk(pin_oe, 32'h00000000);
  endtask
  task automatic t_config;
    wr(12'h56c, 32'h00000013);
    rd(12'h56c, 32'h00000013);
    wr(12'h200, 32'h00000003);
    rd(12'h200, 32'h00000003);
    wr(12'h538, 32'h00000005);
    rd(12'h538, 32'h00000005);
    wr(12'h548, 32'h00000007);
    rd(12'h548, 32'h00000007);
    rd(12'h53c, 32'h00000000);
    rd(12'h02c, 32'h00000000);
  endtask
  task automatic t_pins;
    wr(12'h508, 32'h00000004);
    wr(12'h50c, 32'h00000005);
    wr(12'h510, 32'h00000003);
    wr(12'h514, 32'h00000002);
    wr(12'h500, 32'h00000001);
    repeat (3) @(posedge clk_sys);
    #1 chk(pin_oe & 32'h0000003c, 32'h00000030);
    chk(pin_out & 32'h00000030, 32'h00000030);
    wr(12'h510, 32'h00000006);
    rd(12'h510, 32'h00000003);
    @(posedge clk_sys);
    stall <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(12'h104, 32'h00000001);
    wr(12'h104, 32'h00000000);
    rd(12'h104, 32'h00000000);
    wr(12'h100, 32'h00000000);
    rd(12'h100, 32'h00000000);
    @(posedge clk_sys);
    stall <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(12'h100, 32'h00000001);
  endtask
  // One byte of all ones: only the start bit and the even parity bit are low, four clocks each.
  task automatic t_tx;
    int lows = 0;
    wr(12'h524, 32'h00000004);
    wr(12'h544, 32'h00000100);
    wr(12'h548, 32'h00000001);
    wr(12'h008, 32'h00000001);
    repeat (70) begin
      @(posedge clk_sys);
      #1 if (!pin_out[5]) lows++;
    end
    chk(lows, 32'h00000008);
    chk(n_reads, 32'h00000001);
    chk(dma_rd_addr, 32'h00000100);
    rd(12'h54c, 32'h00000001);
    rd(12'h120, 32'h00000001);
    rd(12'h11c, 32'h00000001);
  endtask
  // One byte from the remote device lands at the buffer start with good parity.
  task automatic t_rx;
    wr(12'h534, 32'h00000200);
    wr(12'h000, 32'h00000001);
    @(posedge clk_sys);
    rx_go <= 1'b1;
    @(posedge clk_sys);
    rx_go <= 1'b0;
    #1 chk(pin_out & 32'h00000010, 32'h00000000);
    repeat (60) @(posedge clk_sys);
    chk(seen_addr, 32'h00000200);
    chk({24'h0, seen_data}, 32'h0000004a);
    rd(12'h108, 32'h00000001);
    rd(12'h53c, 32'h00000001);
    rd(12'h480, 32'h00000000);
  endtask
  // Stop both directions and wait for their events, flush, then disable and drop the system to off.
  task automatic t_off;
    wr(12'h00c, 32'h00000001);
    wr(12'h004, 32'h00000001);
    repeat (4) @(posedge clk_sys);
    rd(12'h158, 32'h00000001);
    rd(12'h144, 32'h00000001);
    rd(12'h110, 32'h00000001);
    wr(12'h110, 32'h00000000);
    wr(12'h200, 32'h00000000);
    wr(12'h02c, 32'h00000001);
    rd(12'h110, 32'h00000001);
    rd(12'h53c, 32'h00000000);
    wr(12'h500, 32'h00000000);
    @(posedge clk_sys);
    system_off <= 1'b1;
    @(posedge clk_sys);
    system_off <= 1'b0;
    #1 chk(pin_oe, 32'h00000000);
    rd(12'h508, 32'hffffffff);
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence after 20 cycles of reset.
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_config();
    t_pins();
    t_tx();
    t_rx();
    t_off();
    report_and_stop();
  end
  // The tests need some 280 cycles; a hang is cut at 4000.
  initial begin
    #20000;
    n_fail++;
    report_and_stop();
  end
endmodule // test_uart_dma_control_map
